// ---- verilog/idau_pkg.sv ----
// Constants and types shared by the indirect data address unit
package idau_pkg;

   // ------------------------------------------------------------
   // Widths
   // ------------------------------------------------------------
   localparam int          ADDR_W    = 12;
   localparam int          DATA_W    = 8;
   localparam int          HIGH_W    = ADDR_W - DATA_W;  // Implemented bits of a high byte
   localparam int          NUM_PTR   = 3;
   localparam int          IDX_W     = 2;
   localparam int          OFF_W     = 3;

   // ------------------------------------------------------------
   // Address map of the pointer blocks, one block of eight bytes per pointer
   // ------------------------------------------------------------
   localparam logic [11:0] PTR_BLOCK_BASE = 12'hFE0;
   localparam logic [11:0] PTR_BLOCK_SPAN = 12'h018;   // Three blocks of eight bytes
   localparam logic [2:0]  OFF_PLAIN      = 3'h0;
   localparam logic [2:0]  OFF_POSTDEC    = 3'h1;
   localparam logic [2:0]  OFF_POSTINC    = 3'h2;
   localparam logic [2:0]  OFF_PREINC     = 3'h3;
   localparam logic [2:0]  OFF_INDEXED    = 3'h4;
   localparam logic [2:0]  OFF_LOW        = 3'h5;
   localparam logic [2:0]  OFF_HIGH       = 3'h6;

   // ------------------------------------------------------------
   // Reset values and fixed answers
   // ------------------------------------------------------------
   localparam logic [11:0] PTR_RESET      = 12'h000;
   localparam logic [11:0] PTR_ONE        = 12'h001;
   localparam logic [7:0]  VIRT_READ_DATA = 8'h00;

   // Automatic pointer step requested by an access
   typedef enum logic [1:0] {STEP_NONE, STEP_INC, STEP_DEC} idau_step_e;

endpackage

// ---- verilog/idau_pointer.sv ----
// One 12-bit pointer register with byte writes and automatic stepping
`timescale 1ns/10ps
module idau_pointer
   import idau_pkg::*;
(
   input  wire logic              core_clk,
   input  wire logic              reset,
   input  wire idau_step_e        stepSel,
   input  wire logic              wrLow,
   input  wire logic              wrHigh,
   input  wire logic [DATA_W-1:0] wrData,
   output logic      [ADDR_W-1:0] value
);

   logic [ADDR_W-1:0] value_reg;
   logic [ADDR_W-1:0] value_next;

   // ------------------------------------------------------------
   // Next value
   // ------------------------------------------------------------
   // Stepping works on all twelve bits, so the low byte carries into the high one
   always_comb
   begin
      value_next = value_reg;
      case (stepSel)
         STEP_INC: value_next = value_reg + PTR_ONE;
         STEP_DEC: value_next = value_reg - PTR_ONE;
         default:  value_next = value_reg;
      endcase
      // A byte write cancels the step entirely, so software sees exactly what it stored
      if (wrLow || wrHigh)
      begin
         value_next = value_reg;
         if (wrLow)
            value_next[DATA_W-1:0] = wrData;
         if (wrHigh)
            value_next[ADDR_W-1:DATA_W] = wrData[HIGH_W-1:0];
      end
   end

   // Register stage
   always_ff @(posedge core_clk)
   begin
      if (reset)
         value_reg <= PTR_RESET;
      else
         value_reg <= value_next;
   end

   assign value = value_reg;

endmodule // idau_pointer

// ---- verilog/idau_unit.sv ----
// Indirect data address unit: three pointers, five virtual locations each
`timescale 1ns/10ps
module idau_unit
   import idau_pkg::*;
(
   input  wire logic              core_clk,
   input  wire logic              reset,
   input  wire logic              accValid,
   input  wire logic              accWrite,
   input  wire logic [ADDR_W-1:0] accAddr,
   input  wire logic [DATA_W-1:0] accWdata,
   input  wire logic [DATA_W-1:0] workingRegister,
   input  wire logic [DATA_W-1:0] ramRdata,
   output logic                   ramValid,
   output logic                   ramWrite,
   output logic      [ADDR_W-1:0] ramAddr,
   output logic      [DATA_W-1:0] ramWdata,
   output logic                   rdValid,
   output logic      [DATA_W-1:0] rdData,
   output logic                   rdZero,
   output logic      [ADDR_W-1:0] pointerZero,
   output logic      [ADDR_W-1:0] pointerOne,
   output logic      [ADDR_W-1:0] pointerTwo
);

   // ------------------------------------------------------------
   // Address decode helpers
   // ------------------------------------------------------------
   function automatic logic inBlock(input logic [ADDR_W-1:0] a);
      inBlock = (a >= PTR_BLOCK_BASE) && (a < PTR_BLOCK_BASE + PTR_BLOCK_SPAN);
   endfunction

   function automatic logic [OFF_W-1:0] blkOff(input logic [ADDR_W-1:0] a);
      logic [ADDR_W-1:0] rel;
      rel    = a - PTR_BLOCK_BASE;
      blkOff = rel[OFF_W-1:0];
   endfunction

   function automatic logic [IDX_W-1:0] blkIdx(input logic [ADDR_W-1:0] a);
      logic [ADDR_W-1:0] rel;
      rel    = a - PTR_BLOCK_BASE;
      blkIdx = rel[OFF_W +: IDX_W];
   endfunction

   function automatic logic isVirt(input logic [ADDR_W-1:0] a);
      isVirt = inBlock(a) && (blkOff(a) <= OFF_INDEXED);
   endfunction

   function automatic logic isPtrByte(input logic [ADDR_W-1:0] a);
      isPtrByte = inBlock(a) && ((blkOff(a) == OFF_LOW) || (blkOff(a) == OFF_HIGH));
   endfunction

   // ------------------------------------------------------------
   // Pointer registers
   // ------------------------------------------------------------
   logic [ADDR_W-1:0] ptrVal  [NUM_PTR];
   idau_step_e        stepSel [NUM_PTR];
   logic              wrLow   [NUM_PTR];
   logic              wrHigh  [NUM_PTR];

   genvar gi;
   generate
      for (gi = 0; gi < NUM_PTR; gi++)
      begin : g_ptr
         idau_pointer idau_pointer_inst
         (
            .core_clk (core_clk),
            .reset    (reset),
            .stepSel  (stepSel[gi]),
            .wrLow    (wrLow[gi]),
            .wrHigh   (wrHigh[gi]),
            .wrData   (accWdata),
            .value    (ptrVal[gi])
         );
      end
   endgenerate

   assign pointerZero = ptrVal[0];
   assign pointerOne  = ptrVal[1];
   assign pointerTwo  = ptrVal[2];

   // ------------------------------------------------------------
   // Address resolution
   // ------------------------------------------------------------
   logic              srcVirt;
   logic [IDX_W-1:0]  srcIdx;
   logic [ADDR_W-1:0] ptrCur;
   logic [ADDR_W-1:0] effAddr;
   idau_step_e        step;
   logic              tgtVirt;
   logic              tgtPtr;
   logic [IDX_W-1:0]  tgtIdx;
   logic [DATA_W-1:0] tgtByte;

   // Source decode picks the pointer and mode, then the target is classified
   always_comb
   begin
      srcVirt = isVirt(accAddr);
      srcIdx  = blkIdx(accAddr);
      ptrCur  = (srcVirt && (srcIdx < IDX_W'(NUM_PTR))) ? ptrVal[srcIdx] : PTR_RESET;
      effAddr = accAddr;
      step    = STEP_NONE;
      if (srcVirt)
      begin
         case (blkOff(accAddr))
            OFF_PLAIN:   effAddr = ptrCur;
            OFF_POSTDEC:
            begin
               effAddr = ptrCur;
               step    = STEP_DEC;
            end
            OFF_POSTINC:
            begin
               effAddr = ptrCur;
               step    = STEP_INC;
            end
            OFF_PREINC:
            begin
               effAddr = ptrCur + PTR_ONE;
               step    = STEP_INC;
            end
            OFF_INDEXED: effAddr = ptrCur + {{HIGH_W{workingRegister[DATA_W-1]}}, workingRegister};
            default:     effAddr = ptrCur;
         endcase
      end
      tgtVirt = isVirt(effAddr);
      tgtPtr  = isPtrByte(effAddr);
      tgtIdx  = blkIdx(effAddr);
      tgtByte = (blkOff(effAddr) == OFF_LOW) ? ptrVal[tgtIdx][DATA_W-1:0]
                                             : DATA_W'(ptrVal[tgtIdx][ADDR_W-1:DATA_W]);
   end

   // Steering of each pointer: its own step, and byte writes that land on it
   always_comb
   begin
      for (int k = 0; k < NUM_PTR; k++)
      begin
         stepSel[k] = (accValid && srcVirt && (srcIdx == IDX_W'(k))) ? step : STEP_NONE;
         wrLow[k]   = accValid && accWrite && tgtPtr && (tgtIdx == IDX_W'(k))
                      && (blkOff(effAddr) == OFF_LOW);
         wrHigh[k]  = accValid && accWrite && tgtPtr && (tgtIdx == IDX_W'(k))
                      && (blkOff(effAddr) == OFF_HIGH);
      end
   end

   // ------------------------------------------------------------
   // Output pipeline
   // ------------------------------------------------------------
   logic              ramValid_reg, ramValid_next;
   logic              ramWrite_reg, ramWrite_next;
   logic [ADDR_W-1:0] ramAddr_reg,  ramAddr_next;
   logic [DATA_W-1:0] ramWdata_reg, ramWdata_next;
   logic              cPend_reg,    cPend_next;
   logic [DATA_W-1:0] cData_reg,    cData_next;
   logic              cZero_reg,    cZero_next;
   logic              rdValid_reg,  rdValid_next;
   logic [DATA_W-1:0] rdData_reg,   rdData_next;
   logic              rdZero_reg,   rdZero_next;

   // Virtual targets never reach the RAM, which keeps stray writes harmless
   always_comb
   begin
      ramValid_next = accValid && !tgtVirt && !tgtPtr;
      ramWrite_next = accValid && accWrite && !tgtVirt && !tgtPtr;
      ramAddr_next  = ramAddr_reg;
      ramWdata_next = ramWdata_reg;
      if (accValid)
      begin
         ramAddr_next  = effAddr;
         ramWdata_next = accWdata;
      end
      cPend_next  = accValid && !accWrite && (tgtVirt || tgtPtr);
      cData_next  = tgtVirt ? VIRT_READ_DATA : tgtByte;
      cZero_next  = tgtVirt;
      // RAM answers during the cycle its address is shown, so both paths line up
      rdValid_next = cPend_reg || (ramValid_reg && !ramWrite_reg);
      rdData_next  = cPend_reg ? cData_reg : ramRdata;
      rdZero_next  = cPend_reg && cZero_reg;
   end

   // Register stage
   always_ff @(posedge core_clk)
   begin
      if (reset)
      begin
         ramValid_reg <= 1'h0;
         ramWrite_reg <= 1'h0;
         ramAddr_reg  <= PTR_RESET;
         ramWdata_reg <= VIRT_READ_DATA;
         cPend_reg    <= 1'h0;
         cData_reg    <= VIRT_READ_DATA;
         cZero_reg    <= 1'h0;
         rdValid_reg  <= 1'h0;
         rdData_reg   <= VIRT_READ_DATA;
         rdZero_reg   <= 1'h0;
      end
      else
      begin
         ramValid_reg <= ramValid_next;
         ramWrite_reg <= ramWrite_next;
         ramAddr_reg  <= ramAddr_next;
         ramWdata_reg <= ramWdata_next;
         cPend_reg    <= cPend_next;
         cData_reg    <= cData_next;
         cZero_reg    <= cZero_next;
         rdValid_reg  <= rdValid_next;
         rdData_reg   <= rdData_next;
         rdZero_reg   <= rdZero_next;
      end
   end

   assign ramValid = ramValid_reg;
   assign ramWrite = ramWrite_reg;
   assign ramAddr  = ramAddr_reg;
   assign ramWdata = ramWdata_reg;
   assign rdValid  = rdValid_reg;
   assign rdData   = rdData_reg;
   assign rdZero   = rdZero_reg;

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (reset);

   logic modePlain, modeDec, modeInc, modePre, modeIdx, ramTgt, selfWr;
   assign modePlain = accValid && srcVirt && (blkOff(accAddr) == OFF_PLAIN);
   assign modeDec   = accValid && srcVirt && (blkOff(accAddr) == OFF_POSTDEC);
   assign modeInc   = accValid && srcVirt && (blkOff(accAddr) == OFF_POSTINC);
   assign modePre   = accValid && srcVirt && (blkOff(accAddr) == OFF_PREINC);
   assign modeIdx   = accValid && srcVirt && (blkOff(accAddr) == OFF_INDEXED);
   assign ramTgt    = !tgtVirt && !tgtPtr;
   assign selfWr    = accValid && accWrite && tgtPtr && (tgtIdx == srcIdx);

   lowByteWrite_a: assert property (accValid && accWrite && !srcVirt && isPtrByte(accAddr)
      && (blkOff(accAddr) == OFF_LOW) && (blkIdx(accAddr) == 2'h1)
      |=> pointerOne[DATA_W-1:0] == $past(accWdata)) else $error("low byte write lost");
   plainAccess_a: assert property (modePlain && ramTgt
      |=> ramValid && ramAddr == $past(ptrCur) && ptrVal[$past(srcIdx)] == $past(ptrCur))
      else $error("plain access wrong");
   postDecrement_a: assert property (modeDec && ramTgt
      |=> ramAddr == $past(ptrCur) && ptrVal[$past(srcIdx)] == $past(ptrCur) - PTR_ONE)
      else $error("post-decrement wrong");
   postIncrement_a: assert property (modeInc && ramTgt
      |=> ramAddr == $past(ptrCur) && ptrVal[$past(srcIdx)] == $past(ptrCur) + PTR_ONE)
      else $error("post-increment wrong");
   preIncrement_a: assert property (modePre && ramTgt
      |=> ramAddr == $past(ptrCur) + PTR_ONE && ptrVal[$past(srcIdx)] == ramAddr)
      else $error("pre-increment wrong");
   indexedAccess_a: assert property (modeIdx && ramTgt |=> ramValid
      && ramAddr == $past(ptrCur) + {{HIGH_W{$past(workingRegister[DATA_W-1])}}, $past(workingRegister)}
      && ptrVal[$past(srcIdx)] == $past(ptrCur)) else $error("indexed access wrong");
   virtRead_a: assert property (accValid && !accWrite && tgtVirt
      |=> !ramValid ##1 rdValid && rdZero && rdData == VIRT_READ_DATA) else $error("virtual read wrong");
   virtWrite_a: assert property (accValid && accWrite && tgtVirt |=> !ramValid && !ramWrite)
      else $error("virtual write reached memory");
   zeroCause_a: assert property (rdZero |-> $past(accValid && !accWrite && tgtVirt, 2))
      else $error("zero flag without virtual read");
   stepCarry_a: assert property ((modeInc || modePre) && !selfWr && ptrCur[DATA_W-1:0] == 8'hFF
      |=> ptrVal[$past(srcIdx)][ADDR_W-1:DATA_W] == $past(ptrCur[ADDR_W-1:DATA_W]) + 4'h1)
      else $error("carry not propagated");
   selfWrite_a: assert property (modeInc && selfWr && blkOff(effAddr) == OFF_LOW
      |=> ptrVal[$past(srcIdx)] == {$past(ptrCur[ADDR_W-1:DATA_W]), $past(accWdata)})
      else $error("write did not dominate step");

   postIncCov_c:  cover property (modeInc ##1 modeInc);
   virtReadCov_c: cover property (accValid && !accWrite && tgtVirt ##2 rdZero);
   indexedCov_c:  cover property (modeIdx && workingRegister[DATA_W-1]);
   selfWriteCov_c: cover property (selfWr && step != STEP_NONE);

endmodule // idau_unit

// ---- test/idau_ram_model.sv ----
// Behavioural data RAM on the far side of the indirect data address unit
`timescale 1ns/10ps
module idau_ram_model
   import idau_pkg::*;
(
   input  wire logic              core_clk,
   input  wire logic              ramValid,
   input  wire logic              ramWrite,
   input  wire logic [ADDR_W-1:0] ramAddr,
   input  wire logic [DATA_W-1:0] ramWdata,
   output logic      [DATA_W-1:0] ramRdata
);
   logic [DATA_W-1:0] mem [4096];
   logic [DATA_W-1:0] noise;

   // Known contents, so the bench can predict every read on its own
   initial
   begin
      noise = 8'hA5;
      for (int i = 0; i < 4096; i++)
         mem[i] = 8'(i) ^ 8'(i >> 4);
   end

   // Writes land on the edge; the idle bus churns so a late sample cannot pass
   always @(posedge core_clk)
   begin
      noise <= noise + 8'h3B;
      if (ramValid && ramWrite)
         mem[ramAddr] <= ramWdata;
   end

   // Read data is combinational while a read strobe is shown
   assign ramRdata = (ramValid && !ramWrite) ? mem[ramAddr] : noise;
endmodule // idau_ram_model

// ---- test/idau_unit_bench.sv ----
// Self-checking bench for the indirect data address unit
`timescale 1ns/10ps
module idau_unit_bench;
   import idau_pkg::*;
   logic              core_clk, reset, accValid, accWrite, ramValid, ramWrite, rdValid, rdZero;
   logic [ADDR_W-1:0] accAddr, ramAddr, pointerZero, pointerOne, pointerTwo;
   logic [DATA_W-1:0] accWdata, workingRegister, ramRdata, ramWdata, rdData;
   logic [ADDR_W-1:0] ptr [NUM_PTR];
   logic [DATA_W-1:0] shadow [4096];
   logic              expRam, expRd, expZero;
   logic [ADDR_W-1:0] expAddr;
   logic [DATA_W-1:0] expData;
   int                errCount, numChecks;

   idau_unit idau_unit_inst (.core_clk(core_clk), .reset(reset), .accValid(accValid), .accWrite(accWrite),
      .accAddr(accAddr), .accWdata(accWdata), .workingRegister(workingRegister), .ramRdata(ramRdata),
      .ramValid(ramValid), .ramWrite(ramWrite), .ramAddr(ramAddr), .ramWdata(ramWdata), .rdValid(rdValid),
      .rdData(rdData), .rdZero(rdZero), .pointerZero(pointerZero), .pointerOne(pointerOne),
      .pointerTwo(pointerTwo));
   idau_ram_model idau_ram_model_inst (.core_clk(core_clk), .ramValid(ramValid), .ramWrite(ramWrite),
      .ramAddr(ramAddr), .ramWdata(ramWdata), .ramRdata(ramRdata));

   // ------------------------------------------------------------
   // Reference model and checking
   // ------------------------------------------------------------
   // Predicts one access and updates the bench's own pointers and memory
   function automatic void predict(input logic wr, input logic [11:0] a, input logic [7:0] d, input logic [7:0] w);
      logic [11:0] t, np;
      int          k, j;
      logic [2:0]  off, toff;
      logic        ind;
      k = 0;
      j = 0;
      off = 3'h7;
      toff = 3'h7;
      ind = 1'h0;
      t = a;
      expRam = 1'h0;
      expRd = !wr;
      expZero = 1'h0;
      expData = 8'h00;
      expAddr = a;
      if (a >= 12'hFE0 && a < 12'hFF8)
      begin
         k = int'((a - 12'hFE0) >> 3);
         off = a[2:0];
      end
      np = ptr[k];
      if (off <= 3'h4)
      begin
         ind = 1'h1;
         if (off == 3'h1) np = ptr[k] - 12'h001;
         if (off == 3'h2 || off == 3'h3) np = ptr[k] + 12'h001;
         t = (off == 3'h3) ? np : (off == 3'h4) ? ptr[k] + {{4{w[7]}}, w} : ptr[k];
      end
      if (t >= 12'hFE0 && t < 12'hFF8)
      begin
         j = int'((t - 12'hFE0) >> 3);
         toff = t[2:0];
      end
      if (ind && toff <= 3'h4)
         expZero = !wr;
      else if (toff == 3'h5 || toff == 3'h6)
      begin
         expData = (toff == 3'h5) ? ptr[j][7:0] : {4'h0, ptr[j][11:8]};
         if (wr && ind && j == k) np = ptr[k];
      end
      else
      begin
         expRam = 1'h1;
         expAddr = t;
         expData = shadow[t];
         if (wr) shadow[t] = d;
      end
      ptr[k] = np;
      if (wr && toff == 3'h5) ptr[j][7:0] = d;
      if (wr && toff == 3'h6) ptr[j][11:8] = d[3:0];
   endfunction

   task automatic check(input logic [11:0] got, input logic [11:0] exp, input string what);
      numChecks++;
      if (got !== exp)
      begin
         errCount++;
         $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   // One access, then the two answer cycles that the hand-over fixes
   task automatic access(input logic wr, input logic [11:0] a, input logic [7:0] d, input logic [7:0] w);
      @(negedge core_clk);
      accValid = 1'h1;
      accWrite = wr;
      accAddr = a;
      accWdata = d;
      workingRegister = w;
      predict(wr, a, d, w);
      @(negedge core_clk);
      accValid = 1'h0;
      accWdata = ~d;
      workingRegister = ~w;
      accAddr = ~a;
      check(12'(ramValid), 12'(expRam), "ram strobe");
      if (expRam) check(12'(ramWrite), 12'(wr), "ram write");
      if (expRam) check(ramAddr, expAddr, "ram address");
      if (expRam && wr) check(12'(ramWdata), 12'(d), "ram data");
      check(pointerZero, ptr[0], "pointer zero");
      check(pointerOne, ptr[1], "pointer one");
      check(pointerTwo, ptr[2], "pointer two");
      @(negedge core_clk);
      check(12'(rdValid), 12'(expRd), "read valid");
      if (!wr) check(12'(rdData), 12'(expData), "read data");
      if (!wr) check(12'(rdZero), 12'(expZero), "read zero");
   endtask

   // Loads a pointer through direct byte writes, high nibble padded with 4'hA
   task automatic setp(input int k, input logic [11:0] v);
      access(1, 12'hFE5 + 12'(8 * k), v[7:0], 8'h00);
      access(1, 12'hFE6 + 12'(8 * k), {4'hA, v[11:8]}, 8'h00);
   endtask

   task automatic completeRun;
      $display("checks %0d, mismatches %0d", numChecks, errCount);
      if (errCount == 0 && numChecks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // ------------------------------------------------------------
   // Clock, watchdog and test sequence
   // ------------------------------------------------------------
   initial
   begin
      core_clk = 0;
      forever #2.5 core_clk = ~core_clk;
   end

   // Every wait is fixed, but a hang still ends in the verdict
   initial
   begin
      #400000;
      errCount++;
      completeRun();
   end

   initial
   begin
      errCount = 0;
      numChecks = 0;
      reset = 1'h1;
      accValid = 1'h0;
      accWrite = 1'h0;
      accAddr = 12'h000;
      accWdata = 8'h00;
      workingRegister = 8'h00;
      for (int i = 0; i < 4096; i++)
         shadow[i] = 8'(i) ^ 8'(i >> 4);
      for (int i = 0; i < NUM_PTR; i++)
         ptr[i] = PTR_RESET;
      void'($urandom(32'h9CF0));
      repeat (2) @(negedge core_clk);
      reset = 1'h0;
      check(pointerZero | pointerOne | pointerTwo, 12'h000, "reset pointers");
      check(12'({ramValid, rdValid}), 12'h000, "reset strobes");
      $display("test reset done");
      // Every pointer through every virtual location, reads and writes
      for (int k = 0; k < NUM_PTR; k++)
         for (int off = 0; off < 5; off++)
            for (int wr = 0; wr < 2; wr++)
            begin
               setp(k, 12'($urandom_range(0, 12'hFDF)));
               access(wr[0], 12'hFE0 + 12'(8 * k + off), 8'($urandom), 8'($urandom));
            end
      $display("test modes done");
      setp(0, 12'h0FF);
      access(0, 12'hFE2, 8'h00, 8'h00);
      access(0, 12'hFE1, 8'h00, 8'h00);
      setp(1, 12'hFFF);
      access(0, 12'hFEA, 8'h00, 8'h00);
      access(1, 12'hFE9, 8'h11, 8'h00);
      setp(2, 12'h005);
      access(0, 12'hFF4, 8'h00, 8'h80);
      access(0, 12'hFF4, 8'h00, 8'h7F);
      setp(2, 12'h001);
      access(0, 12'hFF1, 8'h00, 8'h00);
      access(0, 12'hFF3, 8'h00, 8'h00);
      $display("test carry done");
      setp(0, 12'hFE8);
      access(0, 12'hFE0, 8'h00, 8'h00);
      access(1, 12'hFE2, 8'h77, 8'h00);
      setp(1, 12'hFE0);
      access(0, 12'hFEB, 8'h00, 8'h04);
      access(1, 12'hFEC, 8'h55, 8'h00);
      $display("test virtual done");
      setp(0, 12'hFE5);
      access(1, 12'hFE2, 8'h3C, 8'h00);
      setp(1, 12'hFED);
      access(1, 12'hFEB, 8'h02, 8'h00);
      setp(2, 12'hFEE);
      access(0, 12'hFF1, 8'h00, 8'h00);
      $display("test self write done");
      // Back to back post-increment reads: the second must already use the first one's step
      setp(0, 12'h200);
      @(negedge core_clk);
      accValid = 1'h1;
      accWrite = 1'h0;
      accAddr = 12'hFE2;
      @(negedge core_clk);
      check(ramAddr, 12'h200, "first of pair address");
      @(negedge core_clk);
      accValid = 1'h0;
      check(ramAddr, 12'h201, "second of pair address");
      check(12'(rdValid), 12'h001, "first of pair valid");
      check(12'(rdData), 12'(shadow[12'h200]), "first of pair data");
      check(pointerZero, 12'h202, "pointer after pair");
      ptr[0] = 12'h202;
      @(negedge core_clk);
      check(12'(rdValid), 12'h001, "second of pair valid");
      check(12'(rdData), 12'(shadow[12'h201]), "second of pair data");
      $display("test back to back done");
      // Random mix, biased towards the pointer blocks
      repeat (400)
         access(1'($urandom), $urandom_range(0, 1) ? 12'hFE0 + 12'($urandom_range(0, 23)) : 12'($urandom),
                8'($urandom), 8'($urandom));
      $display("test random done");
      completeRun();
   end
endmodule // idau_unit_bench
